// ### arb_pkg.sv
// constants, register map and rule summary for the secondary bus arbiter
// Function
// - bit 0 enables the bridge's internal requester; resets to 1.
// - bits 1-8 enable external masters 1-8; each resets to 1.
// - read-only bit 9 shows the strap: low internal, high external arbiter.
// - bit 10 set counts 16 idle cycles after grant waiting for frame; reset 0.
// - timeout expiry removes that master's grant and marks it broken.
// - bit 11 clear: a broken master stays ignored once it drops its request.
// - bit 11 set: broken state clears after every other enabled, requesting master is served once.
// - bits 19:12, reset 08h: cycles a grant stays after a competing request.
// - fairness counter reloads from the field on every new grant.
// - fairness counter starts decrementing at the next falling edge of frame.
// - field 00h keeps a grant until its owner drops its request.
// - bit 20 set drops grant one clock after frame held two clocks.
// - bit 20 clear leaves grant asserted after the master asserts frame.
package arb_pkg;
	localparam int ADDR_W = 12;
	localparam int NUM_REQ = 9;
	localparam int OWN_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_RSVD = 12'h044;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h048;
	localparam int F_INT_EN = 0;
	localparam int F_EXT_EN_LO = 1;
	localparam int F_STRAP = 9;
	localparam int F_TO_EN = 10;
	localparam int F_REFRESH = 11;
	localparam int F_FAIR_LO = 12;
	localparam int F_FAIR_HI = 19;
	localparam int F_TOGGLE = 20;
	localparam logic [31:0] RSVD_RESET = 32'h00000000;
	localparam logic [31:0] CTRL_RESET = 32'h000081ff;
	localparam logic [31:0] CTRL_WMASK = 32'h001ffdff;
	localparam int TO_BUS_CYCLES = 16;
	localparam int TOGGLE_FRAME_CLKS = 2;
	localparam logic [4:0] TO_LAST = 5'(TO_BUS_CYCLES - 1);
	localparam logic [1:0] TOGGLE_LAST = 2'(TOGGLE_FRAME_CLKS - 1);
	localparam int PIN_N = NUM_REQ + 1;
endpackage

// ### arb_cfg_if.sv
// configuration carrier between the register slave and the arbiter core
`timescale 1ns/100ps
interface arb_cfg_if;
	logic [8:0] enables;
	logic extArb;
	logic timeoutEn;
	logic refreshEn;
	logic toggleEn;
	logic [7:0] fairInit;
	logic strapHigh;
	modport regs (
		input strapHigh,
		output enables, extArb, timeoutEn, refreshEn, toggleEn, fairInit
	);
	modport core (
		output strapHigh,
		input enables, extArb, timeoutEn, refreshEn, toggleEn, fairInit
	);
endinterface

// ### arb_apb_regs.sv
// apb slave holding the arbiter control word
`timescale 1ns/100ps
module arb_apb_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// apb slave
	input wire logic [arb_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration to the core
	arb_cfg_if.regs cfg
);
	import arb_pkg::*;

	logic [31:0] ctrl_ff;
	logic [31:0] prdata_ff;
	logic slverr_ff;

	wire hitCtrl = (paddr == ADDR_CTRL);
	wire hitRsvd = (paddr == ADDR_RSVD);
	wire setupPh = psel & ~penable;
	wire accessPh = psel & penable;
	wire wrCtrl = accessPh & pwrite & hitCtrl;
	wire [31:0] strapWord = {22'h000000, cfg.strapHigh, 9'h000} ;
	wire [31:0] readWord = hitCtrl ? (ctrl_ff | strapWord) :
		(hitRsvd ? RSVD_RESET : 32'h00000000);
	wire [31:0] nxt_ctrl = wrCtrl ?
		((pwdata & CTRL_WMASK) | (ctrl_ff & ~CTRL_WMASK)) : ctrl_ff;
	wire [31:0] nxt_prdata = setupPh ? readWord : prdata_ff;
	wire nxt_slverr = setupPh ? ~(hitCtrl | hitRsvd) : slverr_ff;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl_ff <= CTRL_RESET;
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			prdata_ff <= nxt_prdata;
			slverr_ff <= nxt_slverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = accessPh;
	assign pslverr = accessPh & slverr_ff;
	assign cfg.enables = ctrl_ff[F_EXT_EN_LO+7:F_INT_EN];
	assign cfg.extArb = cfg.strapHigh;
	assign cfg.timeoutEn = ctrl_ff[F_TO_EN];
	assign cfg.refreshEn = ctrl_ff[F_REFRESH];
	assign cfg.fairInit = ctrl_ff[F_FAIR_HI:F_FAIR_LO];
	assign cfg.toggleEn = ctrl_ff[F_TOGGLE];

	property p_rsvdReadsZero;
		@(posedge ref_clk) disable iff (!rstn)
		(setupPh && hitRsvd) |=> (prdata == 32'h00000000);
	endproperty
	a_rsvdReadsZero: assert property (p_rsvdReadsZero)
		else $error("reserved word not zero");

	property p_strapBit;
		@(posedge ref_clk) disable iff (!rstn)
		(setupPh && hitCtrl) |=> (prdata[F_STRAP] == $past(cfg.strapHigh));
	endproperty
	a_strapBit: assert property (p_strapBit)
		else $error("strap bit wrong");
endmodule

// ### pcix_secondary_bus_arbiter.sv
// secondary bus arbiter: pin synchronisers, grant state machine, fairness
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module pcix_secondary_bus_arbiter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// apb register port
	input wire logic [arb_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// bus pins
	input wire logic [arb_pkg::NUM_REQ-2:0] extReqL,
	output logic [arb_pkg::NUM_REQ-2:0] extGntL,
	input wire logic frameL,
	input wire logic arbiterSelectStrap,
	// internal requester
	input wire logic intReq,
	output logic intGnt
);
	import arb_pkg::*;

	typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT, ARB_BUSY} arb_state_e;

	arb_cfg_if cfgBus ();

	arb_apb_regs u_regs (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cfg(cfgBus.regs)
	);

	// three-stage pin synchronisers
	logic [PIN_N-1:0] sync1_ff;
	logic [PIN_N-1:0] sync2_ff;
	logic [PIN_N-1:0] sync3_ff;
	logic [PIN_N-1:0] pinFilt_ff;
	wire [PIN_N-1:0] pinRaw = {arbiterSelectStrap, frameL, extReqL};
	wire [PIN_N-1:0] nxt_pinFilt = (sync2_ff & sync3_ff) |
		(pinFilt_ff & (sync2_ff | sync3_ff));

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
			sync3_ff <= '1;
			pinFilt_ff <= '1;
		end else begin
			sync1_ff <= pinRaw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			pinFilt_ff <= nxt_pinFilt;
		end
	end

	wire frameAct = ~pinFilt_ff[NUM_REQ-1];
	wire [NUM_REQ-1:0] req = {~pinFilt_ff[NUM_REQ-2:0], intReq};
	assign cfgBus.strapHigh = pinFilt_ff[NUM_REQ];

	// arbitration state
	arb_state_e state_ff;
	arb_state_e nxt_state;
	logic [OWN_W-1:0] owner_ff;
	logic [OWN_W-1:0] nxt_owner;
	logic [7:0] fairCnt_ff;
	logic [7:0] nxt_fairCnt;
	logic fairArmed_ff;
	logic nxt_fairArmed;
	logic [4:0] toCnt_ff;
	logic [4:0] nxt_toCnt;
	logic [1:0] frameCnt_ff;
	logic [1:0] nxt_frameCnt;
	logic toggled_ff;
	logic nxt_toggled;
	logic hole_ff;
	logic frameDly_ff;
	logic [NUM_REQ-1:0] broken_ff;
	logic [NUM_REQ-1:0] served_ff;
	logic [NUM_REQ-1:0] gntVec_ff;
	logic timeoutFire;
	logic releaseFire;

	wire [NUM_REQ-1:0] eligible = req & cfgBus.enables & ~broken_ff &
		{NUM_REQ{~cfgBus.extArb}};
	wire anyElig = |eligible;
	wire frameFall = frameAct & ~frameDly_ff;
	wire [NUM_REQ-1:0] ownerBit = NUM_REQ'(1) << owner_ff;
	wire ownerWant = |(eligible & ownerBit);
	wire othersWant = |(eligible & ~ownerBit);
	wire toggleFire = (state_ff == ARB_BUSY) & cfgBus.toggleEn & frameAct &
		(frameCnt_ff == TOGGLE_LAST) & ~toggled_ff;
	wire refreshFire = cfgBus.refreshEn & (|broken_ff) &
		(&(served_ff | ~(req & cfgBus.enables) | broken_ff));

	// round-robin pick after the last owner
	function automatic logic [OWN_W-1:0] pickNext(
		input logic [NUM_REQ-1:0] elig,
		input logic [OWN_W-1:0] last
	);
		logic [OWN_W-1:0] idx;
		logic [OWN_W-1:0] found;
		found = last;
		for (int k = NUM_REQ; k >= 1; k--) begin
			idx = OWN_W'((int'(last) + k) % NUM_REQ);
			if (elig[idx]) begin
				found = idx;
			end
		end
		return found;
	endfunction

	wire [OWN_W-1:0] pickIdx = pickNext(eligible, owner_ff);

	always_comb begin
		nxt_state = state_ff;
		nxt_owner = owner_ff;
		nxt_fairCnt = fairCnt_ff;
		nxt_fairArmed = fairArmed_ff;
		nxt_toCnt = toCnt_ff;
		nxt_frameCnt = frameCnt_ff;
		nxt_toggled = toggled_ff;
		timeoutFire = 1'b0;
		releaseFire = 1'b0;
		case (state_ff)
			ARB_IDLE: begin
				if (anyElig) begin
					nxt_state = ARB_WAIT;
					nxt_owner = pickIdx;
					nxt_fairCnt = cfgBus.fairInit;
					nxt_fairArmed = 1'b0;
					nxt_toCnt = 5'h00;
					nxt_frameCnt = 2'h0;
					nxt_toggled = 1'b0;
				end
			end
			ARB_WAIT: begin
				if (frameFall) begin
					nxt_state = ARB_BUSY;
					nxt_fairArmed = 1'b1;
					nxt_frameCnt = 2'h1;
				end else if (!ownerWant) begin
					releaseFire = 1'b1;
				end else if (cfgBus.timeoutEn && !frameAct) begin
					if (toCnt_ff == TO_LAST) begin
						timeoutFire = 1'b1;
					end else begin
						nxt_toCnt = toCnt_ff + 5'h01;
					end
				end
				if (timeoutFire || releaseFire) begin
					nxt_state = ARB_IDLE;
				end
			end
			ARB_BUSY: begin
				if (frameAct && frameCnt_ff != 2'h3) begin
					nxt_frameCnt = frameCnt_ff + 2'h1;
				end
				if (toggleFire) begin
					nxt_toggled = 1'b1;
				end
				if (!ownerWant) begin
					releaseFire = 1'b1;
				end else if (cfgBus.fairInit != 8'h00 && fairArmed_ff &&
					othersWant) begin
					if (fairCnt_ff == 8'h00) begin
						releaseFire = 1'b1;
					end else begin
						nxt_fairCnt = fairCnt_ff - 8'h01;
					end
				end
				if (releaseFire) begin
					nxt_state = ARB_IDLE;
				end
			end
			default: begin
				nxt_state = ARB_IDLE;
			end
		endcase
	end

	wire granting = (nxt_state != ARB_IDLE);
	wire [NUM_REQ-1:0] nxtOwnerBit = NUM_REQ'(1) << nxt_owner;
	wire [NUM_REQ-1:0] newGrantBit = (state_ff == ARB_IDLE && granting) ?
		nxtOwnerBit : '0;
	wire [NUM_REQ-1:0] nxt_gntVec = (granting && !toggleFire) ?
		nxtOwnerBit : '0;
	wire [NUM_REQ-1:0] brokenSet = timeoutFire ? ownerBit : '0;
	wire [NUM_REQ-1:0] nxt_broken = (broken_ff & ~{NUM_REQ{refreshFire}}) |
		brokenSet;
	wire [NUM_REQ-1:0] nxt_served = (timeoutFire || refreshFire) ? '0 :
		(served_ff | newGrantBit);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= ARB_IDLE;
			owner_ff <= '0;
			fairCnt_ff <= 8'h00;
			fairArmed_ff <= 1'b0;
			toCnt_ff <= 5'h00;
			frameCnt_ff <= 2'h0;
			toggled_ff <= 1'b0;
			hole_ff <= 1'b0;
			frameDly_ff <= 1'b0;
			broken_ff <= '0;
			served_ff <= '0;
			gntVec_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			owner_ff <= nxt_owner;
			fairCnt_ff <= nxt_fairCnt;
			fairArmed_ff <= nxt_fairArmed;
			toCnt_ff <= nxt_toCnt;
			frameCnt_ff <= nxt_frameCnt;
			toggled_ff <= nxt_toggled;
			hole_ff <= toggleFire;
			frameDly_ff <= frameAct;
			broken_ff <= nxt_broken;
			served_ff <= nxt_served;
			gntVec_ff <= nxt_gntVec;
		end
	end

	assign intGnt = gntVec_ff[0];
	assign extGntL = ~gntVec_ff[NUM_REQ-1:1];

	// checks
	sequence s_frameTwo;
		toggleFire;
	endsequence

	sequence s_holeOne;
		(gntVec_ff == '0 && hole_ff) ##1
		(state_ff != ARB_BUSY || gntVec_ff != '0);
	endsequence

	property p_newGrantEligible;
		@(posedge ref_clk) disable iff (!rstn)
		(state_ff == ARB_IDLE && anyElig) |=>
		((gntVec_ff & ~$past(eligible)) == '0) && (gntVec_ff != '0);
	endproperty
	a_newGrantEligible: assert property (p_newGrantEligible)
		else $error("grant to ineligible requester");

	property p_strapBlocks;
		@(posedge ref_clk) disable iff (!rstn)
		cfgBus.extArb [*2] |=> (gntVec_ff == '0);
	endproperty
	a_strapBlocks: assert property (p_strapBlocks)
		else $error("grant while external arbiter selected");

	property p_timeoutDrops;
		@(posedge ref_clk) disable iff (!rstn)
		timeoutFire |=> (gntVec_ff == '0) && broken_ff[$past(owner_ff)];
	endproperty
	a_timeoutDrops: assert property (p_timeoutDrops)
		else $error("timeout did not drop grant");

	property p_timeoutCount;
		@(posedge ref_clk) disable iff (!rstn)
		timeoutFire |-> (toCnt_ff == TO_LAST) && cfgBus.timeoutEn &&
		(state_ff == ARB_WAIT) && !$past(frameAct, 15);
	endproperty
	a_timeoutCount: assert property (p_timeoutCount)
		else $error("timeout fired early");

	property p_reload;
		@(posedge ref_clk) disable iff (!rstn)
		(state_ff == ARB_IDLE && anyElig) |=>
		(fairCnt_ff == $past(cfgBus.fairInit)) && !fairArmed_ff;
	endproperty
	a_reload: assert property (p_reload)
		else $error("fairness not reloaded");

	property p_armOnFrame;
		@(posedge ref_clk) disable iff (!rstn)
		(state_ff == ARB_WAIT && !fairArmed_ff) ##1 fairArmed_ff |->
		$past(frameFall);
	endproperty
	a_armOnFrame: assert property (p_armOnFrame)
		else $error("armed without frame fall");

	property p_holdZero;
		@(posedge ref_clk) disable iff (!rstn)
		(state_ff == ARB_BUSY && cfgBus.fairInit == 8'h00 && ownerWant) |=>
		(state_ff == ARB_BUSY) && $stable(owner_ff);
	endproperty
	a_holdZero: assert property (p_holdZero)
		else $error("grant removed with zero fairness");

	property p_toggle;
		@(posedge ref_clk) disable iff (!rstn)
		s_frameTwo |=> s_holeOne;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("grant toggle wrong");

	property p_noToggle;
		@(posedge ref_clk) disable iff (!rstn)
		(!cfgBus.toggleEn && state_ff == ARB_BUSY &&
		nxt_state == ARB_BUSY) |=> (gntVec_ff == ownerBit);
	endproperty
	a_noToggle: assert property (p_noToggle)
		else $error("grant dropped while toggling disabled");

	property p_brokenStays;
		@(posedge ref_clk) disable iff (!rstn)
		!cfgBus.refreshEn |=> (($past(broken_ff) & ~broken_ff) == '0);
	endproperty
	a_brokenStays: assert property (p_brokenStays)
		else $error("broken master released");

	property p_refresh;
		@(posedge ref_clk) disable iff (!rstn)
		(refreshFire && !timeoutFire) |=> (broken_ff == '0);
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("broken state not refreshed");

	property p_fairRelease;
		@(posedge ref_clk) disable iff (!rstn)
		(state_ff == ARB_BUSY && ownerWant && othersWant && fairArmed_ff &&
		cfgBus.fairInit != 8'h00 && fairCnt_ff == 8'h00) |=>
		(gntVec_ff == '0);
	endproperty
	a_fairRelease: assert property (p_fairRelease)
		else $error("fairness expiry kept grant");
endmodule

// ### ext_master_model.sv
// behavioural model of the external bus masters sharing one frame line
`timescale 1ns/100ps
module ext_master_model (
	// clock
	input wire logic ref_clk,
	// bench control: who wants the bus, who never starts
	input wire logic [7:0] want,
	input wire logic [7:0] lazy,
	// bus pins
	input wire logic [7:0] extGntL,
	output logic [7:0] extReqL,
	output logic frameL
);
	localparam int FRAME_LEN = 10;
	int cnt;
	initial begin
		extReqL = 8'hff;
		frameL = 1'b1;
		cnt = 0;
	end
	// request, then frame once granted on an idle bus
	always @(posedge ref_clk) begin
		extReqL <= ~want;
		if (cnt > 0) begin
			cnt <= cnt - 1;
			frameL <= (cnt == 1);
		end else if (frameL && (|(~extGntL & want & ~lazy))) begin
			cnt <= FRAME_LEN;
			frameL <= 1'b0;
		end
	end
endmodule

// ### pcix_secondary_bus_arbiter_tb.sv
// self-checking bench for the secondary bus arbiter
`timescale 1ns/100ps
module pcix_secondary_bus_arbiter_tb;
	import arb_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] extReqL;
	logic [7:0] extGntL;
	logic frameL;
	logic strap = 1'b0;
	logic intGnt;
	logic [8:0] reqs = '0;
	logic [7:0] lazy = '0;
	logic [8:0] granted;
	logic [31:0] rd;
	logic err;
	int miscompares = 0;
	int testsRun = 0;
	// index 0 internal requester, 1..8 external masters
	assign granted = {~extGntL, intGnt};
	always #5 ref_clk = ~ref_clk;
	pcix_secondary_bus_arbiter u_pcix_secondary_bus_arbiter (
		.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extReqL(extReqL), .extGntL(extGntL), .frameL(frameL),
		.arbiterSelectStrap(strap), .intReq(reqs[0]), .intGnt(intGnt)
	);
	ext_master_model u_ext_master_model (
		.ref_clk(ref_clk), .want(reqs[8:1]), .lazy(lazy),
		.extGntL(extGntL), .extReqL(extReqL), .frameL(frameL)
	);
	task check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task summarize;
		if (miscompares == 0 && testsRun > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task doReset;
		rstn <= 1'b0;
		cyc(16);
		rstn <= 1'b1;
		cyc(8);
	endtask
	// one apb transfer; read data and error taken at the pready edge
	task apb(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", pready, 1'b1);
	endtask
	task waitGnt(input int i, input logic lvl, input int lim);
		int n;
		n = 0;
		while (granted[i] !== lvl && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		check($sformatf("grant %0d", i), granted[i], lvl);
	endtask
	task holdVec(input logic [8:0] exp, input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(posedge ref_clk);
			if (granted !== exp) bad++;
		end
		check("grant hold", bad, 0);
	endtask
	task testRegs;
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h000081ff);
		apb(1'b1, ADDR_CTRL, 32'hffffffff);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl rw", rd, 32'h001ffdff);
		apb(1'b1, ADDR_RSVD, 32'hffffffff);
		apb(1'b0, ADDR_RSVD, 32'h0);
		check("reserved", rd, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped", err, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h000081ff);
	endtask
	task testEnables;
		apb(1'b1, ADDR_CTRL, 32'h00008000);
		reqs <= 9'h1ff;
		holdVec(9'h000, 40);
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, ADDR_CTRL, 32'h00008000 | (32'h1 << i));
			waitGnt(i, 1'b1, 30);
		end
		reqs <= '0;
		apb(1'b1, ADDR_CTRL, 32'h000081ff);
		cyc(20);
	endtask
	task testStrap;
		strap <= 1'b1;
		cyc(10);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("strap bit", rd[9], 1'b1);
		reqs <= 9'h002;
		holdVec(9'h000, 30);
		strap <= 1'b0;
		waitGnt(1, 1'b1, 20);
		reqs <= '0;
		cyc(20);
	endtask
	task testGrant;
		reqs <= 9'h004;
		waitGnt(2, 1'b1, 20);
		holdVec(9'h004, 12);
		reqs <= '0;
		waitGnt(2, 1'b0, 20);
	endtask
	task testTimeout;
		apb(1'b1, ADDR_CTRL, 32'h000085ff);
		lazy <= 8'h02;
		reqs <= 9'h004;
		waitGnt(2, 1'b1, 20);
		holdVec(9'h004, 13);
		waitGnt(2, 1'b0, 8);
		reqs <= '0;
		cyc(6);
		lazy <= '0;
		reqs <= 9'h004;
		holdVec(9'h000, 40);
		reqs <= '0;
	endtask
	task testRefresh;
		apb(1'b1, ADDR_CTRL, 32'h00008dff);
		lazy <= 8'h02;
		reqs <= 9'h004;
		waitGnt(2, 1'b1, 20);
		waitGnt(2, 1'b0, 30);
		reqs <= '0;
		lazy <= '0;
		cyc(6);
		reqs <= 9'h008;
		waitGnt(3, 1'b1, 20);
		cyc(12);
		reqs <= '0;
		waitGnt(3, 1'b0, 20);
		reqs <= 9'h004;
		waitGnt(2, 1'b1, 30);
		reqs <= '0;
		cyc(20);
	endtask
	task testToggle;
		apb(1'b1, ADDR_CTRL, 32'h001081ff);
		reqs <= 9'h010;
		waitGnt(4, 1'b1, 20);
		waitGnt(4, 1'b0, 12);
		@(posedge ref_clk);
		check("toggle one clock", granted[4], 1'b1);
		reqs <= '0;
		apb(1'b1, ADDR_CTRL, 32'h000081ff);
		cyc(20);
	endtask
	task testFairness;
		apb(1'b1, ADDR_CTRL, 32'h000001ff);
		reqs <= 9'h020;
		waitGnt(5, 1'b1, 20);
		reqs <= 9'h060;
		holdVec(9'h020, 60);
		reqs <= 9'h040;
		waitGnt(6, 1'b1, 30);
		reqs <= '0;
		cyc(20);
		apb(1'b1, ADDR_CTRL, 32'h000021ff);
		reqs <= 9'h020;
		waitGnt(5, 1'b1, 20);
		cyc(4);
		reqs <= 9'h060;
		waitGnt(5, 1'b0, 30);
		waitGnt(6, 1'b1, 30);
		reqs <= '0;
		cyc(20);
	endtask
	initial begin
		doReset;
		testRegs;
		testEnables;
		testStrap;
		testGrant;
		testTimeout;
		doReset;
		testRefresh;
		testToggle;
		testFairness;
		summarize;
	end
	// hang guard at 10000 cycles, well beyond the several hundred cycles the tests take
	initial begin
		#100000;
		miscompares++;
		summarize;
	end
endmodule
